// ---- inc/iop_pkg.sv ----
/*
 Shared constants of the process I/O port block: register offsets, field
 positions, reset values, timing counts and the strap capture state.
 Assumes one 125 MHz system clock.
*/
package iop_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
   // ==========================================================
   // Port layout
   localparam int NPORT = 8;
   localparam int NCHAN = 4;
   localparam int PORT_E = 4;
   localparam int UP_LSB = 4;
   localparam int UP_E_LSB = PORT_E * 8 + UP_LSB;
   localparam logic [2:0] DIAG_CNT = 3'h6;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] A_OUT = 8'h00;
   localparam logic [7:0] A_IN = 8'h08;
   localparam logic [7:0] A_DIAG = 8'h10;
   localparam logic [7:0] A_PRM1 = 8'h18;
   localparam logic [7:0] A_MASK = 8'h1c;
   localparam logic [7:0] A_CTRL = 8'h20;
   localparam logic [7:0] A_STATUS = 8'h21;
   localparam logic [7:0] A_CFG = 8'h22;
   // ==========================================================
   // Fields
   localparam int CTRL_SYNC_MODE = 0;
   localparam int CTRL_FREEZE_MODE = 1;
   localparam int CTRL_SYNC_CMD = 4;
   localparam int CTRL_FREEZE_CMD = 5;
   localparam int CTRL_WD_TIMEOUT = 6;
   localparam int PRM1_GROUP = 3;
   localparam int ST_ERR = 0;
   localparam int ST_CHANGED = 1;
   localparam int ST_EXT = 2;
   localparam int ST_PM = 3;
   localparam int ST_RUN = 4;
   // ==========================================================
   // Reset values
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] PRM1_RST = 8'h00;
   typedef enum logic [0:0] {
      IOP_CFG_WAIT = 1'h0,
      IOP_CFG_RUN = 1'h1
   } iop_cfg_t;
endpackage : iop_pkg

// ---- hw/iop_tick.sv ----
/*
 Sample divider: one-cycle enable every SAMPLE_CYCLES clocks.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module iop_tick
   import iop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Enable
   output logic tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } iop_tick_st_t;

   iop_tick_st_t st_reg;
   iop_tick_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = (st_reg.cnt == 8'h00);
      st_next.cnt = st_next.tick ? SAMPLE_LAST : st_reg.cnt - 8'h01;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;
endmodule : iop_tick

`default_nettype wire

// ---- hw/iop_diag_eval.sv ----
/*
 Diagnostic evaluation: turns sampled low levels into error bits, applies
 channel masks and the group combine flag. Purely combinational.
 Assumes its inputs come from one simultaneous sample.
*/
`timescale 1ns/100ps
`default_nettype none

module iop_diag_eval
   import iop_pkg::*;
(
   // Sampled pins, channel F in bits 7:0
   input wire logic [31:0] ch_pins,
   input wire logic [7:0] j_pins,
   input wire logic [7:0] k_pins,
   // Configuration
   input wire logic ext,
   input wire logic pm,
   input wire logic [3:0] dg,
   input wire logic [31:0] mask,
   input wire logic group_flag,
   // Errors
   output logic [31:0] ch_err,
   output logic [7:0] j_err,
   output logic [7:0] k_err,
   output logic any_err
);
   logic ch_any;

   for (genvar c = 0; c < NCHAN; c++) begin : g_chan
      // Low pin is an error, passed only with mask bit clear
      assign ch_err[c*8 +: 8] = (ext && dg[c]) ? (~ch_pins[c*8 +: 8] & ~mask[c*8 +: 8]) : 8'h00;
   end

   // General ports exist only with a parameter memory and are never masked
   assign j_err = pm ? ~j_pins : 8'h00;
   assign k_err = pm ? ~k_pins : 8'h00;
   assign ch_any = |ch_err;
   assign any_err = ch_any | (|k_err) | ((|j_err) & (!group_flag | ch_any));
endmodule : iop_diag_eval

`default_nettype wire

// ---- hw/iop_io_port.sv ----
/*
 Process I/O port block: eight strap-configured 8-bit data ports, channel
 and general diagnosis, sync and freeze gating, register port for the
 telegram sequencer.
 Assumes field pins are synchronous to sys_clk and the sequencer is the
 only register master.
*/
// Function
// - Type pins 11x select extended diagnosis
// - Upper type bits refine port directions
// - Unused data ports are driven outputs
// - Ports A-D, F-H, E or I
// - F-I channel diagnosis; J, K need memory
// - Diagnosis sampled with data ports
// - Low diagnostic pin means error one
// - Per-bit channel masks, clear after reset
// - J and K never masked
// - Flag zero: any J low errors
// - Flag one: J needs channel error
// - Any K low always errors
// - Error output follows present error levels
// - Report each diagnostic change once
// - Freeze holds inputs, sync holds outputs
// - Error indicator high only on error
// - Watchdog timeout zeroes all outputs
// - Masks and flag from parameter bytes
// - Channel bytes zero without extended diagnosis
`timescale 1ns/100ps
`default_nettype none

module iop_io_port
   import iop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Configuration straps
   input wire logic [2:0] type_sel_pins,
   input wire logic param_memory_select,
   // Data ports A-H, port A in bits 7:0
   input wire logic [63:0] data_pin_in,
   output logic [63:0] data_pin_out,
   output logic [63:0] data_pin_oe,
   // Port I and general diagnostic ports
   input wire logic [7:0] port_i_in,
   input wire logic [7:0] port_j_in,
   input wire logic [7:0] port_k_in,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Indicators
   output logic diag_error_output,
   output logic diag_event
);
   // ==========================================================
   // State
   typedef struct packed {
      iop_cfg_t cfg_st;
      logic [2:0] typ;
      logic [2:0] up;
      logic pm;
      logic ext;
      logic [7:0] outm;
      logic [7:0] unum;
      logic [3:0] dg;
      logic [7:0][7:0] pending;
      logic [7:0][7:0] applied;
      logic [7:0] prm1;
      logic [3:0][7:0] mask;
      logic sync_mode;
      logic freeze_mode;
      logic [7:0][7:0] cur_in;
      logic [7:0] cur_i;
      logic [7:0] cur_j;
      logic [7:0] cur_k;
      logic [7:0][7:0] in_vis;
      logic [5:0][7:0] diag_vis;
      logic changed;
      logic diag_event;
      logic diag_err;
      logic [63:0] pin_out;
      logic [63:0] pin_oe;
      logic [7:0] rdata;
   } iop_state_t;

   iop_state_t st_reg;
   iop_state_t st_next;
   logic tick;
   logic run;
   logic wr_ctrl;
   logic sync_cmd;
   logic freeze_cmd;
   logic wd_cmd;
   logic [31:0] ch_err;
   logic [7:0] j_err;
   logic [7:0] k_err;
   logic any_err;
   logic [5:0][7:0] err_bytes;
   logic [63:0] unused_x;

   assign run = (st_reg.cfg_st == IOP_CFG_RUN);
   assign wr_ctrl = reg_wr && (reg_addr == A_CTRL);
   assign sync_cmd = wr_ctrl && reg_wdata[CTRL_SYNC_CMD];
   assign freeze_cmd = wr_ctrl && reg_wdata[CTRL_FREEZE_CMD];
   assign wd_cmd = wr_ctrl && reg_wdata[CTRL_WD_TIMEOUT];
   assign err_bytes = {ch_err, k_err, j_err};

   iop_tick u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick)
   );

   // Port I doubles as channel diagnosis after F-H
   iop_diag_eval u_eval (
      .ch_pins({st_reg.cur_i, st_reg.cur_in[7], st_reg.cur_in[6], st_reg.cur_in[5]}),
      .j_pins(st_reg.cur_j),
      .k_pins(st_reg.cur_k),
      .ext(st_reg.ext),
      .pm(st_reg.pm),
      .dg(st_reg.dg),
      .mask(st_reg.mask),
      .group_flag(st_reg.prm1[PRM1_GROUP]),
      .ch_err(ch_err),
      .j_err(j_err),
      .k_err(k_err),
      .any_err(any_err)
   );

   // ==========================================================
   // Direction table
   // Result {out A-H, unused A-H, 4'h0} for plain rows and
   // {8'h00, out A-D, unused A-D, diag F-I} for extended rows, A in MSB.
   function automatic logic [19:0] dec_tab(input logic [5:0] code);
      logic [15:0] n;
      logic [11:0] e;
      n = 16'h0000;
      e = 12'h000;
      case (code)
         6'h03: n = 16'h0007;
         6'h04: n = 16'h000f;
         6'h05: n = 16'h001f;
         6'h06: n = 16'h003f;
         6'h07: n = 16'h007f;
         6'h08: n = 16'h8000;
         6'h09: n = 16'h8000;
         6'h0a: n = 16'h8003;
         6'h0b: n = 16'h8007;
         6'h0c: n = 16'h800f;
         6'h0d: n = 16'h801f;
         6'h0e: n = 16'h803f;
         6'h0f: n = 16'h807f;
         6'h10: n = 16'hc000;
         6'h11: n = 16'hc001;
         6'h12: n = 16'hc003;
         6'h13: n = 16'hc007;
         6'h14: n = 16'hc00f;
         6'h15: n = 16'hc01f;
         6'h16: n = 16'hc03f;
         6'h17: n = 16'hff00;
         6'h18: n = 16'he000;
         6'h19: n = 16'he001;
         6'h1a: n = 16'he003;
         6'h1b: n = 16'he003;
         6'h1c: n = 16'he00f;
         6'h1d: n = 16'he01f;
         6'h1e: n = 16'h00ff;
         6'h1f: n = 16'h00ff;
         6'h20: n = 16'hf000;
         6'h21: n = 16'hf001;
         6'h22: n = 16'hf003;
         6'h23: n = 16'hf007;
         6'h24: n = 16'hf807;
         6'h25: n = 16'hfc00;
         6'h26: n = 16'h00ff;
         6'h27: n = 16'h00ff;
         6'h28: n = 16'hf800;
         6'h29: n = 16'hf801;
         6'h2a: n = 16'hf803;
         6'h2b: n = 16'hf807;
         6'h2c: n = 16'hfe00;
         6'h2d: n = 16'hfc01;
         6'h2e: n = 16'hfe01;
         6'h2f: n = 16'hfc03;
         6'h30: e = 12'h078;
         6'h31: e = 12'h03c;
         6'h32: e = 12'h01e;
         6'h33: e = 12'h00f;
         6'h34: e = 12'h878;
         6'h35: e = 12'hc3c;
         6'h36: e = 12'he1e;
         6'h37: e = 12'hf0f;
         6'h38: e = 12'h83c;
         6'h39: e = 12'hc1e;
         6'h3a: e = 12'he0f;
         6'h3b: e = 12'h81e;
         6'h3c: e = 12'hc0f;
         6'h3d: e = 12'h80f;
         6'h3e: e = 12'h0f0;
         6'h3f: e = 12'h0f0;
         default: n = 16'h0000;
      endcase
      return (code[5] & code[4]) ? {8'h00, e} : {n, 4'h0};
   endfunction : dec_tab

   // ==========================================================
   // Next state
   always_comb begin
      logic [19:0] dv;
      logic [7:0] ob;
      logic [7:0] ub;
      logic [3:0] dgb;
      logic ext_now;
      logic vis_upd;
      dv = 20'h00000;
      ob = 8'h00;
      ub = 8'h00;
      dgb = 4'h0;
      ext_now = 1'b0;
      vis_upd = 1'b0;
      st_next = st_reg;
      st_next.diag_event = 1'b0;

      // Straps are caught once, on the first edge after reset
      if (!run) begin
         ext_now = type_sel_pins[2] & type_sel_pins[1];
         st_next.typ = type_sel_pins;
         st_next.pm = param_memory_select;
         st_next.ext = ext_now;
         // Refining bits sit on port E in extended mode, else on port I
         st_next.up = ext_now ? data_pin_in[UP_E_LSB +: 3] : port_i_in[UP_LSB +: 3];
         dv = dec_tab({type_sel_pins, st_next.up});
         if (ext_now) begin
            ob = {dv[11:8], 4'h0};
            ub = {dv[7:4], 1'b0, ~dv[3:1]};
            dgb = dv[3:0];
         end else begin
            ob = dv[19:12];
            ub = dv[11:4];
         end
         for (int p = 0; p < NPORT; p++) begin
            st_next.outm[p] = ob[7 - p];
            st_next.unum[p] = ub[7 - p];
         end
         for (int c = 0; c < NCHAN; c++) begin
            st_next.dg[c] = dgb[3 - c];
         end
         st_next.cfg_st = IOP_CFG_RUN;
      end

      if (reg_wr) begin
         if (reg_addr[7:3] == A_OUT[7:3]) begin
            st_next.pending[reg_addr[2:0]] = reg_wdata;
         end
         if (reg_addr == A_PRM1) begin
            st_next.prm1 = reg_wdata;
         end
         if (reg_addr[7:2] == A_MASK[7:2]) begin
            st_next.mask[reg_addr[1:0]] = reg_wdata;
         end
         if (wr_ctrl) begin
            st_next.sync_mode = reg_wdata[CTRL_SYNC_MODE];
            st_next.freeze_mode = reg_wdata[CTRL_FREEZE_MODE];
         end
         if (reg_addr == A_STATUS && reg_wdata[ST_CHANGED]) begin
            st_next.changed = 1'b0;
         end
      end

      // Timeout wins over a same-cycle data write
      if (wd_cmd) begin
         st_next.pending = '0;
         st_next.applied = '0;
      end else if (!st_reg.sync_mode || sync_cmd) begin
         st_next.applied = st_reg.pending;
      end

      // Data and diagnostic pins share one sample instant
      if (tick) begin
         st_next.cur_in = data_pin_in;
         st_next.cur_i = port_i_in;
         st_next.cur_j = port_j_in;
         st_next.cur_k = port_k_in;
      end

      vis_upd = (tick && !st_reg.freeze_mode) || freeze_cmd;
      if (vis_upd) begin
         st_next.in_vis = st_reg.cur_in;
         st_next.diag_vis = err_bytes;
         // Placed after the clear so a new change is never lost
         if (err_bytes != st_reg.diag_vis) begin
            st_next.diag_event = 1'b1;
            st_next.changed = 1'b1;
         end
      end

      st_next.diag_err = any_err;

      // Unused ports drive low so the board needs no pull-ups
      for (int p = 0; p < NPORT; p++) begin
         st_next.pin_oe[p*8 +: 8] = {8{run && (st_reg.outm[p] || st_reg.unum[p])}};
         st_next.pin_out[p*8 +: 8] = (run && st_reg.outm[p]) ? st_reg.applied[p] : 8'h00;
      end

      st_next.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr[7:3] == A_OUT[7:3]) begin
            st_next.rdata = st_reg.pending[reg_addr[2:0]];
         end else if (reg_addr[7:3] == A_IN[7:3]) begin
            st_next.rdata = st_reg.in_vis[reg_addr[2:0]];
         end else if (reg_addr[7:3] == A_DIAG[7:3] && reg_addr[2:0] < DIAG_CNT) begin
            st_next.rdata = st_reg.diag_vis[reg_addr[2:0]];
         end else if (reg_addr == A_PRM1) begin
            st_next.rdata = st_reg.prm1;
         end else if (reg_addr[7:2] == A_MASK[7:2]) begin
            st_next.rdata = st_reg.mask[reg_addr[1:0]];
         end else if (reg_addr == A_CTRL) begin
            st_next.rdata[CTRL_SYNC_MODE] = st_reg.sync_mode;
            st_next.rdata[CTRL_FREEZE_MODE] = st_reg.freeze_mode;
         end else if (reg_addr == A_STATUS) begin
            st_next.rdata[ST_ERR] = st_reg.diag_err;
            st_next.rdata[ST_CHANGED] = st_reg.changed;
            st_next.rdata[ST_EXT] = st_reg.ext;
            st_next.rdata[ST_PM] = st_reg.pm;
            st_next.rdata[ST_RUN] = run;
         end else if (reg_addr == A_CFG) begin
            st_next.rdata = {2'h0, st_reg.up, st_reg.typ};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '0;
         // Pins start at their idle high level; zeros would read as errors
         st_reg.cur_in <= '1;
         st_reg.cur_i <= '1;
         st_reg.cur_j <= '1;
         st_reg.cur_k <= '1;
         st_reg.prm1 <= PRM1_RST;
         st_reg.mask <= {NCHAN{MASK_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign data_pin_out = st_reg.pin_out;
   assign data_pin_oe = st_reg.pin_oe;
   assign reg_rdata = st_reg.rdata;
   assign diag_error_output = st_reg.diag_err;
   assign diag_event = st_reg.diag_event;

   // ==========================================================
   // Checks
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         unused_x[p*8 +: 8] = {8{st_reg.unum[p]}};
      end
   end

   a_ext_select: assert property (@(posedge sys_clk) disable iff (rst)
      run |-> st_reg.ext == (st_reg.typ[2] & st_reg.typ[1]))
      else $error("extended mode does not match type pins");

   a_unused_drive: assert property (@(posedge sys_clk) disable iff (rst)
      run |=> ((st_reg.pin_oe & unused_x) == unused_x) && ((st_reg.pin_out & unused_x) == 64'h0))
      else $error("unused port not driven low");

   a_mask_clear: assert property (@(posedge sys_clk) disable iff (rst)
      !run |-> st_reg.mask == '0)
      else $error("masks not clear after reset");

   a_group_gate: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.prm1[PRM1_GROUP] && ch_err == 32'h0 && k_err == 8'h00 |=> !diag_error_output)
      else $error("port J error passed without channel error");

   a_k_error: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.pm && st_reg.cur_k != 8'hff |=> diag_error_output)
      else $error("port K low did not raise error");

   a_err_clear: assert property (@(posedge sys_clk) disable iff (rst)
      !any_err |=> !diag_error_output)
      else $error("error output stayed high without error");

   a_event_cause: assert property (@(posedge sys_clk) disable iff (rst)
      diag_event |-> st_reg.changed && st_reg.diag_vis != $past(st_reg.diag_vis))
      else $error("diagnostic event without change");

   a_sync_hold: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.sync_mode && !sync_cmd && !wd_cmd |=> $stable(st_reg.applied))
      else $error("outputs updated without sync");

   a_sync_apply: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.sync_mode && sync_cmd && !wd_cmd |=> st_reg.applied == $past(st_reg.pending))
      else $error("sync did not apply pending outputs");

   a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.freeze_mode && !freeze_cmd |=> $stable(st_reg.in_vis) && $stable(st_reg.diag_vis))
      else $error("inputs updated while frozen");

   a_wd_force: assert property (@(posedge sys_clk) disable iff (rst)
      wd_cmd |=> st_reg.applied == '0 ##1 data_pin_out == 64'h0)
      else $error("timeout did not zero outputs");

   a_noext_zero: assert property (@(posedge sys_clk) disable iff (rst)
      !st_reg.ext |-> st_reg.diag_vis[5:2] == '0)
      else $error("channel bytes nonzero without extended mode");

   a_cfg_hold: assert property (@(posedge sys_clk) disable iff (rst)
      run |=> run && $stable({st_reg.typ, st_reg.up, st_reg.pm, st_reg.outm, st_reg.unum}))
      else $error("port arrangement changed after capture");
endmodule : iop_io_port

`default_nettype wire

// ---- tb/iop_field_model.sv ----
/*
 Field side of the port block: switches and sensors on input pins,
 actuators that read back the pins the block drives.
 Assumes level pins with no clock; the bench sets the field levels.
*/
`timescale 1ns/100ps
`default_nettype none

module iop_field_model (
   // Pins from the block
   input wire logic [63:0] data_pin_out,
   input wire logic [63:0] data_pin_oe,
   // Levels set by the field devices
   input wire logic [63:0] field_level,
   // Pin level seen by the block
   output logic [63:0] data_pin_in
);
   // ==========================================================
   // Wire level
   // A driven pin reads back its own drive, so contention with the field level never shows
   assign data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & field_level);
endmodule : iop_field_model

`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 Top bench of the port block: one plain and one diagnosis strap setup,
 register tasks for the sequencer port, pin checks through the field model.
 Assumes a 125 MHz clock and the sample tick of the package.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import iop_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] type_sel_pins = 3'h0;
   logic param_memory_select = 1'b0;
   logic [63:0] field_drv = '1;
   logic [63:0] data_pin_in, data_pin_out, data_pin_oe;
   logic [7:0] port_i_in = 8'hff;
   logic [7:0] port_j_in = 8'hff;
   logic [7:0] port_k_in = 8'hff;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic diag_error_output, diag_event;
   int miscompares = 0;
   int compares = 0;
   int events = 0;

   always #4 sys_clk = ~sys_clk;

   iop_io_port i_iop_io_port (.sys_clk(sys_clk), .rst(rst), .type_sel_pins(type_sel_pins),
      .param_memory_select(param_memory_select), .data_pin_in(data_pin_in),
      .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .port_i_in(port_i_in),
      .port_j_in(port_j_in), .port_k_in(port_k_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .diag_error_output(diag_error_output), .diag_event(diag_event));

   iop_field_model i_iop_field_model (.data_pin_out(data_pin_out),
      .data_pin_oe(data_pin_oe), .field_level(field_drv), .data_pin_in(data_pin_in));

   always @(posedge sys_clk) begin
      if (diag_event === 1'b1) begin
         events++;
      end
   end

   // ==========================================================
   // Common tasks
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask : check_bit

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : settle

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check_byte(reg_rdata, exp);
   endtask : read_check

   task automatic do_reset(input logic [2:0] t, input logic pm, input logic [7:0] pi);
      @(posedge sys_clk);
      rst <= 1'b1;
      type_sel_pins <= t;
      param_memory_select <= pm;
      port_i_in <= pi;
      settle(8);
      rst <= 1'b0;
      settle(3);
   endtask : do_reset

   task automatic check_oe(input logic [63:0] exp);
      for (int p = 0; p < NPORT; p++) begin
         check_byte(data_pin_oe[8*p+:8], exp[8*p+:8]);
      end
   endtask : check_oe

   // ==========================================================
   // Scenarios
   task automatic test_plain();
      do_reset(3'h1, 1'b0, 8'h40);
      read_check(A_CFG, 8'h21);
      read_check(A_STATUS, 8'h10);
      check_oe(64'hffffffff000000ff);
      for (int p = 0; p < NCHAN; p++) begin
         read_check(A_MASK + 8'(p), MASK_RST);
         reg_write(A_MASK + 8'(p), 8'h00);
      end
      field_drv[15:8] <= 8'h3c;
      reg_write(A_OUT, 8'h5a);
      settle(300);
      check_byte(data_pin_out[7:0], 8'h5a);
      read_check(A_IN + 8'h01, 8'h3c);
      read_check(A_DIAG + 8'h02, 8'h00);
      reg_write(A_CTRL, 8'h40);
      settle(3);
      check_byte(data_pin_out[7:0], 8'h00);
   endtask : test_plain

   task automatic test_ext_diag();
      field_drv <= '1;
      do_reset(3'h6, 1'b1, 8'hff);
      read_check(A_STATUS, 8'h1c);
      read_check(A_CFG, 8'h3e);
      check_oe(64'h00000000ffffffff);
      events = 0;
      field_drv[47:40] <= 8'hfe;
      settle(300);
      check_bit(diag_error_output, 1'b1);
      settle(300);
      read_check(A_DIAG + 8'h02, 8'h01);
      check_byte(8'(events), 8'h01);
      read_check(A_STATUS, 8'h1f);
      reg_write(A_STATUS, 8'h02);
      read_check(A_STATUS, 8'h1d);
      reg_write(A_MASK, 8'h01);
      settle(300);
      check_bit(diag_error_output, 1'b0);
   endtask : test_ext_diag

   task automatic test_general();
      port_k_in <= 8'h7f;
      settle(300);
      check_bit(diag_error_output, 1'b1);
      read_check(A_DIAG + 8'h01, 8'h80);
      port_k_in <= 8'hff;
      port_j_in <= 8'hfe;
      settle(300);
      check_bit(diag_error_output, 1'b1);
      reg_write(A_PRM1, 8'h08);
      settle(300);
      check_bit(diag_error_output, 1'b0);
      reg_write(A_MASK, 8'h00);
      settle(300);
      check_bit(diag_error_output, 1'b1);
      port_j_in <= 8'hff;
      field_drv[47:40] <= 8'hff;
      settle(300);
      check_bit(diag_error_output, 1'b0);
   endtask : test_general

   task automatic test_freeze_sync();
      reg_write(A_CTRL, 8'h02);
      field_drv[55:48] <= 8'hef;
      settle(300);
      read_check(A_DIAG + 8'h03, 8'h00);
      reg_write(A_CTRL, 8'h22);
      settle(3);
      read_check(A_DIAG + 8'h03, 8'h10);
      reg_write(A_CTRL, 8'h00);
      reg_write(A_OUT, 8'h5a);
      settle(5);
      check_byte(data_pin_out[7:0], 8'h5a);
      reg_write(A_CTRL, 8'h01);
      reg_write(A_OUT, 8'h33);
      settle(5);
      check_byte(data_pin_out[7:0], 8'h5a);
      reg_write(A_CTRL, 8'h11);
      settle(5);
      check_byte(data_pin_out[7:0], 8'h33);
   endtask : test_freeze_sync

   // ==========================================================
   // Sequence and watchdog
   initial begin
      test_plain();
      test_ext_diag();
      test_general();
      test_freeze_sync();
      stop_test();
   end

   // Whole run needs about 25 us; the limit leaves ample margin
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
